//--- logic/adcc_map.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH
`define ADCC_OFF_CTRL0       12'h000
`define ADCC_OFF_CTRL1       12'h004
`define ADCC_OFF_RES_HIGH    12'h008
`define ADCC_OFF_RES_LOW     12'h00C
`define ADCC_OFF_STATUS      12'h010
`define ADCC_OFF_TRIG        12'h014
`define ADCC_CTRL0_RESET     8'h00
`define ADCC_CTRL1_RESET     8'h00
`define ADCC_CTRL1_MASK      8'hB0
`define ADCC_CLKSEL_HI       7
`define ADCC_CLKSEL_LO       6
`define ADCC_CHAN_HI         5
`define ADCC_CHAN_LO         2
`define ADCC_GO_BIT          1
`define ADCC_ON_BIT          0
`define ADCC_JUSTIFY_BIT     7
`define ADCC_NREF_BIT        5
`define ADCC_PREF_BIT        4
`define ADCC_DONE_BIT        0
`define ADCC_DIV_SYS2        8'h02
`define ADCC_DIV_SYS8        8'h08
`define ADCC_DIV_SYS32       8'h20
`define ADCC_CLK_HZ          40000000
`define ADCC_RC_MAX_HZ       500000
`define ADCC_RC_HALF         ((`ADCC_CLK_HZ + 2 * `ADCC_RC_MAX_HZ - 1) / (2 * `ADCC_RC_MAX_HZ))
`define ADCC_CONV_PERIODS    5'h0B
`define ADCC_ABORT_PERIODS   5'h02
`define ADCC_RES_ZERO        10'h000
`endif

//--- logic/adcc_pkg.sv
// Types shared by the converter control modules
package adcc_pkg;
  typedef enum logic [3:0] {
    ADCC_IDLE  = 4'b0001,
    ADCC_CONV  = 4'b0010,
    ADCC_ABORT = 4'b0100,
    ADCC_DONE  = 4'b1000
  } adcc_state_e;
  typedef logic [9:0] adcc_result_t;
endpackage

//--- logic/adcc_tick_if.sv
// Conversion clock selection and period ticks between control and divider
`timescale 1ns/1ps
interface adcc_tick_if;
  logic [1:0] clk_select;
  logic       run;
  logic       tick;
  modport ctrl (output clk_select, output run, input tick);
  modport gen  (input clk_select, input run, output tick);
endinterface

//--- logic/adcc_tick_gen.sv
// Conversion bit period tick generator with system and internal RC sources
`timescale 1ns/1ps
`include "adcc_map.svh"
module adcc_tick_gen
  import adcc_pkg::*;
#(
  parameter int RC_HALF = `ADCC_RC_HALF
) (
  input wire logic pclk,
  input wire logic presetn,
  adcc_tick_if.gen tk
);
  typedef struct packed {
    logic [7:0]  sys_cnt;
    logic [15:0] rc_cnt;
    logic        rc_clk;
    logic        rc_prev;
    logic        tick;
  } adcc_tick_s;
  adcc_tick_s st;
  adcc_tick_s next_st;
  logic [7:0] div;
  assign tk.tick = st.tick;
  always_comb begin
    next_st = st;
    div = `ADCC_DIV_SYS2;
    next_st.tick = 1'b0;
    unique case (tk.clk_select)
      2'h0: div = `ADCC_DIV_SYS2;
      2'h1: div = `ADCC_DIV_SYS8;
      2'h2: div = `ADCC_DIV_SYS32;
      2'h3: div = `ADCC_DIV_SYS32;
    endcase
    if (st.rc_cnt >= 16'(RC_HALF - 1)) begin
      next_st.rc_cnt = 16'h0000;
      next_st.rc_clk = ~st.rc_clk;
    end else begin
      next_st.rc_cnt = st.rc_cnt + 16'h0001;
    end
    next_st.rc_prev = st.rc_clk;
    if (!tk.run) begin
      next_st.sys_cnt = 8'h00;
    end else if (tk.clk_select == 2'h3) begin
      next_st.tick = st.rc_clk & ~st.rc_prev;
    end else if (st.sys_cnt >= div - 8'h01) begin
      next_st.sys_cnt = 8'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.sys_cnt = st.sys_cnt + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

//--- logic/adcc_top.sv
// Converter control and result registers behind an APB slave
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "adcc_map.svh"
// Functional notes
// - Clock select picks sys/2, /8, /32, RC
// - RC conversion clock runs free, 500 kHz max
// - Channel codes 0..13 route analog pins
// - Code 14 comparator ref, 15 fixed ref
// - Go write starts, reads one while converting
// - Hardware clears go at conversion end
// - Converter runs only while enabled
// - Justify bit picks right or left layout
// - Negative ref: pin when one, ground zero
// - Positive ref: pin when one, supply zero
// - Left layout: bits 9..2 high byte
// - Left layout: bits 1..0 low top
// - Right layout: bits 9..8 high bottom
// - Right layout: bits 7..0 low byte
// - Unused control-one bits read zero
// - Hold capacitor never discharged by logic
// - Completion clears go, flags, loads result
// - Abort keeps result, waits two periods
// - Done flag always set, software clears
// - Compare trigger sets go in hardware
module adcc_top
  import adcc_pkg::*;
#(
  parameter int RC_HALF = `ADCC_RC_HALF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        special_trigger,
  input  wire logic        core_bit_valid,
  input  wire logic        core_bit,
  output logic             converter_on,
  output logic [3:0]       input_channel_select,
  output logic [15:0]      analog_pin_select,
  output logic             comparator_ref_route,
  output logic             fixed_ref_route,
  output logic             negative_ref_select,
  output logic             positive_ref_select,
  output logic             conv_bit_strobe,
  output logic             conversion_busy,
  output logic             acquire,
  output logic             conversion_done_flag
);
  typedef struct packed {
    logic [7:0]   ctrl0;
    logic [7:0]   ctrl1;
    logic [7:0]   res_high;
    logic [7:0]   res_low;
    adcc_result_t shift;
    logic [4:0]   periods;
    adcc_state_e  state;
    logic         done_flag;
    logic         trig_enable;
    logic [31:0]  rdata;
    logic [15:0]  pin_sel;
  } adcc_regs_s;
  adcc_regs_s r;
  adcc_regs_s next_r;
  adcc_tick_if tk ();
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic go_req;

  adcc_tick_gen #(
    .RC_HALF (RC_HALF)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk.gen)
  );

  // Places a result by layout; used at completion
  function automatic logic [15:0] adcc_layout(input adcc_result_t v, input logic right);
    logic [15:0] o;
    o = 16'h0000;
    if (right) begin
      o[9:8] = v[9:8];
      o[7:0] = v[7:0];
    end else begin
      o[15:8] = v[9:2];
      o[7:6] = v[1:0];
    end
    return o;
  endfunction

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && !penable && !pwrite;
  assign mapped = hit(paddr, `ADCC_OFF_CTRL0) || hit(paddr, `ADCC_OFF_CTRL1)
               || hit(paddr, `ADCC_OFF_RES_HIGH) || hit(paddr, `ADCC_OFF_RES_LOW)
               || hit(paddr, `ADCC_OFF_STATUS) || hit(paddr, `ADCC_OFF_TRIG);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = r.rdata;

  assign converter_on         = r.ctrl0[`ADCC_ON_BIT];
  assign input_channel_select = r.ctrl0[`ADCC_CHAN_HI:`ADCC_CHAN_LO];
  assign analog_pin_select    = r.pin_sel;
  assign comparator_ref_route = converter_on && input_channel_select == 4'hE;
  assign fixed_ref_route      = converter_on && input_channel_select == 4'hF;
  assign negative_ref_select  = r.ctrl1[`ADCC_NREF_BIT];
  assign positive_ref_select  = r.ctrl1[`ADCC_PREF_BIT];
  assign conv_bit_strobe      = tk.tick && r.state == ADCC_CONV;
  assign conversion_busy      = r.state != ADCC_IDLE;
  assign acquire              = converter_on && r.state == ADCC_IDLE;
  assign conversion_done_flag = r.done_flag;
  assign tk.clk_select        = r.ctrl0[`ADCC_CLKSEL_HI:`ADCC_CLKSEL_LO];
  assign tk.run               = converter_on && r.state != ADCC_IDLE;

  always_comb begin
    logic [15:0] lay;
    logic        sw_go;
    lay = 16'h0000;
    sw_go = 1'b0;
    next_r = r;
    go_req = 1'b0;
    next_r.pin_sel = 16'h0000;
    if (converter_on && input_channel_select <= 4'hD) begin
      next_r.pin_sel[input_channel_select] = 1'b1;
    end
    if (rd_en) begin
      next_r.rdata = 32'h0000_0000;
      if (hit(paddr, `ADCC_OFF_CTRL0)) begin
        next_r.rdata[7:0] = r.ctrl0;
      end else if (hit(paddr, `ADCC_OFF_CTRL1)) begin
        next_r.rdata[7:0] = r.ctrl1 & `ADCC_CTRL1_MASK;
      end else if (hit(paddr, `ADCC_OFF_RES_HIGH)) begin
        next_r.rdata[7:0] = r.res_high;
      end else if (hit(paddr, `ADCC_OFF_RES_LOW)) begin
        next_r.rdata[7:0] = r.res_low;
      end else if (hit(paddr, `ADCC_OFF_STATUS)) begin
        next_r.rdata[`ADCC_DONE_BIT] = r.done_flag;
      end else if (hit(paddr, `ADCC_OFF_TRIG)) begin
        next_r.rdata[0] = r.trig_enable;
      end
    end
    if (wr_en && pstrb[0]) begin
      if (hit(paddr, `ADCC_OFF_CTRL0)) begin
        next_r.ctrl0 = pwdata[7:0];
        next_r.ctrl0[`ADCC_GO_BIT] = r.ctrl0[`ADCC_GO_BIT];
        sw_go = pwdata[`ADCC_GO_BIT];
        if (!pwdata[`ADCC_GO_BIT] && r.state == ADCC_CONV) begin
          next_r.ctrl0[`ADCC_GO_BIT] = 1'b0;
          next_r.state = ADCC_ABORT;
          next_r.periods = 5'h00;
        end
      end else if (hit(paddr, `ADCC_OFF_CTRL1)) begin
        next_r.ctrl1 = pwdata[7:0] & `ADCC_CTRL1_MASK;
      end else if (hit(paddr, `ADCC_OFF_RES_HIGH)) begin
        next_r.res_high = pwdata[7:0];
      end else if (hit(paddr, `ADCC_OFF_RES_LOW)) begin
        next_r.res_low = pwdata[7:0];
      end else if (hit(paddr, `ADCC_OFF_STATUS)) begin
        if (pwdata[`ADCC_DONE_BIT]) begin
          next_r.done_flag = 1'b0;
        end
      end else if (hit(paddr, `ADCC_OFF_TRIG)) begin
        next_r.trig_enable = pwdata[0];
      end
    end
    go_req = sw_go || (special_trigger && r.trig_enable);
    unique case (r.state)
      ADCC_IDLE: begin
        if (go_req && next_r.ctrl0[`ADCC_ON_BIT]) begin
          next_r.ctrl0[`ADCC_GO_BIT] = 1'b1;
          next_r.state = ADCC_CONV;
          next_r.periods = 5'h00;
          next_r.shift = `ADCC_RES_ZERO;
        end
      end
      ADCC_CONV: begin
        if (core_bit_valid && tk.tick) begin
          next_r.shift = {r.shift[8:0], core_bit};
        end
        if (tk.tick && next_r.state == ADCC_CONV) begin
          next_r.periods = r.periods + 5'h01;
          if (r.periods == `ADCC_CONV_PERIODS - 5'h01) begin
            next_r.state = ADCC_DONE;
          end
        end
      end
      ADCC_ABORT: begin
        if (tk.tick) begin
          next_r.periods = r.periods + 5'h01;
          if (r.periods == `ADCC_ABORT_PERIODS - 5'h01) begin
            next_r.state = ADCC_IDLE;
          end
        end
      end
      ADCC_DONE: begin
        lay = adcc_layout(r.shift, r.ctrl1[`ADCC_JUSTIFY_BIT]);
        next_r.res_high = lay[15:8];
        next_r.res_low = lay[7:0];
        next_r.ctrl0[`ADCC_GO_BIT] = 1'b0;
        next_r.done_flag = 1'b1;
        next_r.state = ADCC_IDLE;
      end
    endcase
    if (!next_r.ctrl0[`ADCC_ON_BIT] && r.state != ADCC_IDLE) begin
      next_r.state = ADCC_IDLE;
      next_r.ctrl0[`ADCC_GO_BIT] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '{ctrl0: `ADCC_CTRL0_RESET, ctrl1: `ADCC_CTRL1_RESET,
             state: ADCC_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end
endmodule

//--- verif/adcc_properties.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module adcc_properties #(
  parameter int RC_HALF = 2
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  input wire logic        converter_on,
  input wire logic [3:0]  input_channel_select,
  input wire logic [15:0] analog_pin_select,
  input wire logic        comparator_ref_route,
  input wire logic        fixed_ref_route,
  input wire logic        negative_ref_select,
  input wire logic        positive_ref_select,
  input wire logic        conv_bit_strobe,
  input wire logic        conversion_busy,
  input wire logic        acquire,
  input wire logic        conversion_done_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       busy_q;
  logic [3:0] n_strobe;
  logic [3:0] chan_q;
  logic       on_q;
  wire        wr_en = psel && penable && pwrite && pstrb[0];
  wire        held = input_channel_select == chan_q && converter_on && on_q;
  // Bit periods seen since the conversion began
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q   <= 1'b0;
      n_strobe <= 4'h0;
      chan_q   <= 4'h0;
      on_q     <= 1'b0;
    end else begin
      busy_q   <= conversion_busy;
      chan_q   <= input_channel_select;
      on_q     <= converter_on;
      if (conversion_busy && !busy_q) n_strobe <= {3'h0, conv_bit_strobe};
      else if (conv_bit_strobe) n_strobe <= n_strobe + 4'h1;
    end
  end
  ref_select_a: assert property (wr_en && paddr == 12'h004 |=>
    negative_ref_select == $past(pwdata[5]) && positive_ref_select == $past(pwdata[4]))
    else $error("reference selects do not follow the written control byte");
  pin_route_a: assert property (held && input_channel_select < 4'hE |->
    analog_pin_select == (16'h0001 << input_channel_select))
    else $error("analog pin select does not match the channel code");
  cmp_ref_a: assert property (held && input_channel_select == 4'hE |->
    comparator_ref_route && !fixed_ref_route)
    else $error("comparator reference not routed for code 14");
  fixed_ref_a: assert property (held && input_channel_select == 4'hF |->
    fixed_ref_route && !comparator_ref_route)
    else $error("fixed reference not routed for code 15");
  off_quiet_a: assert property (!converter_on && !$past(converter_on) |->
    analog_pin_select == 16'h0000 && !acquire && !conv_bit_strobe)
    else $error("converter active while switched off");
  conv_len_a: assert property ($rose(conversion_done_flag) |-> n_strobe == 4'hB)
    else $error("conversion did not last eleven bit periods");
  flag_hold_a: assert property (conversion_done_flag &&
    !(wr_en && paddr == 12'h010 && pwdata[0]) |=> conversion_done_flag)
    else $error("done flag dropped without a software clear");
  acquire_idle_a: assert property (acquire |-> converter_on && !conversion_busy)
    else $error("acquire raised while off or busy");
  slverr_map_a: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("unmapped access not refused");
  cover property ($rose(conversion_done_flag));
  cover property (conv_bit_strobe && conversion_busy);
  cover property (pslverr);
endmodule
bind adcc_top adcc_properties #(
  .RC_HALF (RC_HALF)
) u_props (
  .pclk                 (pclk),
  .presetn              (presetn),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .pstrb                (pstrb),
  .pslverr              (pslverr),
  .converter_on         (converter_on),
  .input_channel_select (input_channel_select),
  .analog_pin_select    (analog_pin_select),
  .comparator_ref_route (comparator_ref_route),
  .fixed_ref_route      (fixed_ref_route),
  .negative_ref_select  (negative_ref_select),
  .positive_ref_select  (positive_ref_select),
  .conv_bit_strobe      (conv_bit_strobe),
  .conversion_busy      (conversion_busy),
  .acquire              (acquire),
  .conversion_done_flag (conversion_done_flag)
);

//--- verif/adcc_core_model.sv
// Conversion core stand-in feeding result bits MSB first
`timescale 1ns/1ps
module adcc_core_model (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       conv_bit_strobe,
  input wire logic       conversion_busy,
  input wire logic [9:0] value,
  output logic           core_bit_valid,
  output logic           core_bit
);
  logic [3:0] n_bit;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) n_bit <= 4'h0;
    else if (!conversion_busy) n_bit <= 4'h0;
    else if (conv_bit_strobe) n_bit <= n_bit + 4'h1;
  end
  assign core_bit_valid = conversion_busy && n_bit < 4'hA;
  // Outside valid bits the line toggles so a stale bit cannot pass
  assign core_bit = core_bit_valid ? value[4'h9 - n_bit] : n_bit[0] ^ pclk;
endmodule

//--- verif/adcc_top_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adcc_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, special_trigger;
  logic        pready, pslverr, core_bit_valid, core_bit, converter_on;
  logic        comparator_ref_route, fixed_ref_route, negative_ref_select;
  logic        positive_ref_select, conv_bit_strobe, conversion_busy, acquire;
  logic        conversion_done_flag;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb, input_channel_select;
  logic [15:0] analog_pin_select, e;
  logic [9:0]  value, lastv;
  logic        err;
  logic [15:0] q[$];
  int          n_mismatch = 0;
  int          n_compared = 0;
  adcc_top #(
    .RC_HALF (2)
  ) DUT (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (pstrb),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .special_trigger      (special_trigger),
    .core_bit_valid       (core_bit_valid),
    .core_bit             (core_bit),
    .converter_on         (converter_on),
    .input_channel_select (input_channel_select),
    .analog_pin_select    (analog_pin_select),
    .comparator_ref_route (comparator_ref_route),
    .fixed_ref_route      (fixed_ref_route),
    .negative_ref_select  (negative_ref_select),
    .positive_ref_select  (positive_ref_select),
    .conv_bit_strobe      (conv_bit_strobe),
    .conversion_busy      (conversion_busy),
    .acquire              (acquire),
    .conversion_done_flag (conversion_done_flag)
  );
  adcc_core_model u_core (
    .pclk            (pclk),
    .presetn         (presetn),
    .conv_bit_strobe (conv_bit_strobe),
    .conversion_busy (conversion_busy),
    .value           (value),
    .core_bit_valid  (core_bit_valid),
    .core_bit        (core_bit)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Read data is compared against the oldest note when the access completes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && q.size() > 0) begin
      e = q.pop_front();
      check(prdata & {24'h0, e[15:8]}, {24'h0, e[7:0]});
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [15:0] x);
    int n;
    if (!w) q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 16'h0000);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m = 8'hFF);
    apb(1'b0, a, 8'h00, {m, x});
  endtask
  task automatic poll_idle();
    int n;
    n = 0;
    do begin
      rd(12'h000, 8'h00, 8'h00);
      n++;
    end while (r[1] !== 1'b0 && n < 400);
    if (r[1] !== 1'b0) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic conv(input logic [1:0] cs, input logic j, input logic [9:0] v);
    value = v;
    wr(12'h004, {j, 7'h00});
    wr(12'h000, {cs, 6'h01});
    repeat (20) @(posedge pclk);
    wr(12'h000, {cs, 6'h03});
    rd(12'h000, {cs, 6'h03});
    poll_idle();
    rd(12'h000, {cs, 6'h01});
    rd(12'h010, 8'h01, 8'h01);
    rd(12'h008, j ? {6'h0, v[9:8]} : v[9:2], j ? 8'h03 : 8'hFF);
    rd(12'h00C, j ? v[7:0] : {v[1:0], 6'h0}, j ? 8'hFF : 8'hC0);
    wr(12'h010, 8'h01);
    rd(12'h010, 8'h00, 8'h01);
  endtask
  initial begin
    void'($urandom(32'hDA40214E));
    {presetn, psel, penable, pwrite, special_trigger} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    value = 10'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 8'h00);
    rd(12'h004, 8'h00);
    check({negative_ref_select, positive_ref_select}, 2'h0);
    wr(12'h004, 8'hFF);
    check({negative_ref_select, positive_ref_select}, 2'h3);
    rd(12'h004, 8'hB0);
    for (int c = 0; c < 16; c++) begin
      wr(12'h000, {2'b00, c[3:0], 2'b01});
      repeat (2) @(posedge pclk);
      check(analog_pin_select, c < 14 ? 32'h1 << c : 32'h0);
      check(input_channel_select, c[3:0]);
      check({comparator_ref_route, fixed_ref_route}, c == 14 ? 2 : c == 15 ? 1 : 0);
    end
    wr(12'h000, 8'h02);
    rd(12'h000, 8'h00);
    for (int k = 0; k < 4; k++) conv(k[1:0], k[0], 10'($urandom));
    lastv = value;
    wr(12'h004, 8'h00);
    rd(12'h008, {6'h0, lastv[9:8]}, 8'h03);
    value = ~lastv;
    wr(12'h000, 8'hC3);
    repeat (10) @(posedge pclk);
    wr(12'h000, 8'hC1);
    rd(12'h00C, lastv[7:0]);
    repeat (12) @(posedge pclk);
    check(acquire, 1);
    rd(12'h010, 8'h00, 8'h01);
    wr(12'h00C, 8'h5A);
    rd(12'h00C, 8'h5A);
    check(err, 1'b0);
    rd(12'h020, 8'h00);
    check(err, 1'b1);
    wr(12'h014, 8'h01);
    value = 10'($urandom);
    special_trigger <= 1'b1;
    @(posedge pclk) special_trigger <= 1'b0;
    repeat (2) @(posedge pclk);
    poll_idle();
    rd(12'h010, 8'h01, 8'h01);
    rd(12'h008, value[9:2]);
    end_of_test();
  end
endmodule
